/* File: logic/complementary_waveform_control.sv */
// Complementary waveform controller: steering, auto-shutdown, dead band, AHB-Lite registers
//
// Summary of operation
// (RQ1) Polarity bit 1 inverts its output, 0 passes it unchanged.
// (RQ2) Clock source bit selects fast internal oscillator ticks or system clock.
// (RQ3) Four-bit code picks the data input: 0 pin, 1-15 internal sources.
// (RQ4) Steering enabled output carries the data input with its polarity applied.
// (RQ5) Steering disabled output drives its override level, ignoring polarity.
// (RQ6) Steering and override bits act only in the two steering modes.
// (RQ7) In synchronous steering, steering enables update only at data rising edges.
// (RQ8) Shutdown status reads 1 while shutdown is in effect; hardware sets and clears.
// (RQ9) Auto-restart clears shutdown by hardware; otherwise software must clear it.
// (RQ10) After shutdown clears, outputs hold shutdown state until next data rising edge.
// (RQ11) Software may write shutdown while disabled to force shutdown configuration.
// (RQ12) Outputs B and D shutdown code: high, low, tri-state or inactive level.
// (RQ13) Outputs A and C shutdown code uses the same encoding.
// (RQ14) Inactive shutdown level applies only after the dead-band interval elapses.
// (RQ15) Seven shutdown sources each have an enable bit; bit 7 is reserved.
// (RQ16) Rising dead band lasts n to n+1 dead-band clock periods.
// (RQ17) Falling dead band lasts n to n+1 dead-band clock periods.
// (RQ18) A dead-band count of zero bypasses the delay.
// (RQ19) Dead-band counts are not cleared by reset and keep their value.
// (RQ20) Mode field: steering async/sync, full bridge fwd/rev, half bridge, push-pull; the code drives codes 2 to 5 all as half bridge.
// (RQ21) Load bit reloads dead-band buffers at rise after next fall, then self-clears.
// (RQ22) Any enabled active shutdown source sets shutdown and forces shutdown states; the code acts on sources only while the module is enabled.
module complementary_waveform_control (
  input wire logic clk, // 40 MHz clock
  input wire logic rst_n, // Synchronous reset
  input wire logic ce, // Clock enable, freezes all state
  input wire waveform_ctrl_pkg::ahb_req_s ahb_req, // AHB-Lite request group
  output logic hreadyout, // Always ready
  output logic hresp, // Always OKAY
  output logic [31:0] hrdata, // Read data
  input wire logic pin_mapped_input, // Data input pin
  input wire logic [14:0] internal_src, // Internal sources for codes 1 to 15
  input wire logic [waveform_ctrl_pkg::NUM_SRC-1:0] shutdown_src, // Shutdown sources, high active
  input wire logic fast_osc_tick, // One-cycle ticks of the fast internal oscillator
  output waveform_ctrl_pkg::pin_drive_s drive // Output A..D levels and enables
);
  import waveform_ctrl_pkg::*;

  // Registers
  logic cs_reg, en_reg, load_deadband_buffers, shutdown_reg, ren_reg;
  logic [3:0] input_source_code;
  logic [DB_W-1:0] rising_deadband_value, falling_deadband_value;
  logic [2:0] mode_reg;
  logic [NUM_OUT-1:0] output_invert, override_level, steering_enable;
  logic [1:0] shutdown_state_bd, shutdown_state_ac;
  logic [7:0] shutdown_source_enable_bit;

  // Bus
  logic wr_pend_reg, addr_take;
  logic [9:0] wr_idx_reg, addr_idx;
  logic [31:0] hrdata_reg;
  logic [7:0] rd_mux, wdata;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
  assign addr_idx = ahb_req.haddr[ADDR_W-1:2];
  assign addr_take = ahb_req.hsel & ahb_req.hready & ahb_req.htrans[1];
  assign wdata = ahb_req.hwdata[7:0];

  logic wr_clk, wr_ism, wr_dbr, wr_dbf, wr_con0, wr_con1, wr_as0, wr_as1, wr_str;
  assign wr_clk = wr_pend_reg & (wr_idx_reg == IDX_CLK);
  assign wr_ism = wr_pend_reg & (wr_idx_reg == IDX_ISM);
  assign wr_dbr = wr_pend_reg & (wr_idx_reg == IDX_DBR);
  assign wr_dbf = wr_pend_reg & (wr_idx_reg == IDX_DBF);
  assign wr_con0 = wr_pend_reg & (wr_idx_reg == IDX_CON0);
  assign wr_con1 = wr_pend_reg & (wr_idx_reg == IDX_CON1);
  assign wr_as0 = wr_pend_reg & (wr_idx_reg == IDX_AS0);
  assign wr_as1 = wr_pend_reg & (wr_idx_reg == IDX_AS1);
  assign wr_str = wr_pend_reg & (wr_idx_reg == IDX_STR);

  // Data input selection and edges
  logic [15:0] data_sources;
  logic data_in, data_q_reg, data_rise, data_fall;
  // (RQ3) input source mux
  assign data_sources = {internal_src, pin_mapped_input};
  assign data_in = data_sources[input_source_code];
  assign data_rise = data_in & ~data_q_reg;
  assign data_fall = ~data_in & data_q_reg;

  // Dead-band clock tick
  logic db_tick;
  // (RQ2) dead-band clock select
  assign db_tick = cs_reg ? fast_osc_tick : 1'b1;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 10'h000;
      hrdata_reg <= 32'h0000_0000;
    end else if (ce) begin
      wr_pend_reg <= addr_take & ahb_req.hwrite;
      if (addr_take) begin
        wr_idx_reg <= addr_idx;
      end
      if (addr_take & ~ahb_req.hwrite) begin
        hrdata_reg <= {24'h00_0000, rd_mux};
      end
    end
  end

  always_comb begin
    case (addr_idx)
      IDX_CLK: rd_mux = {7'h00, cs_reg};
      IDX_ISM: rd_mux = {4'h0, input_source_code};
      IDX_DBR: rd_mux = {2'h0, rising_deadband_value};
      IDX_DBF: rd_mux = {2'h0, falling_deadband_value};
      IDX_CON0: rd_mux = {en_reg, load_deadband_buffers, 3'h0, mode_reg};
      IDX_CON1: rd_mux = {2'h0, data_in, 1'b0, output_invert};
      IDX_AS0: rd_mux = {shutdown_reg, ren_reg, shutdown_state_bd, shutdown_state_ac, 2'h0};
      IDX_AS1: rd_mux = shutdown_source_enable_bit;
      IDX_STR: rd_mux = {override_level, steering_enable};
      default: rd_mux = 8'h00;
    endcase
  end

  // Plain configuration registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cs_reg <= 1'b0;
      input_source_code <= 4'h0;
      en_reg <= 1'b0;
      mode_reg <= MODE_RST;
      output_invert <= 4'h0;
      ren_reg <= 1'b0;
      shutdown_state_bd <= SHUTDOWN_STATE_BD_RST;
      shutdown_state_ac <= SHUTDOWN_STATE_AC_RST;
      shutdown_source_enable_bit <= 8'h00;
      override_level <= 4'h0;
      steering_enable <= 4'h0;
    end else if (ce) begin
      if (wr_clk) cs_reg <= wdata[0];
      if (wr_ism) input_source_code <= wdata[3:0];
      if (wr_con0) begin
        en_reg <= wdata[CON0_EN];
        mode_reg <= wdata[2:0];
      end
      if (wr_con1) output_invert <= wdata[NUM_OUT-1:0];
      if (wr_as0) begin
        ren_reg <= wdata[AS0_REN];
        shutdown_state_bd <= wdata[AS0_SHUTDOWN_STATE_BD+1:AS0_SHUTDOWN_STATE_BD];
        shutdown_state_ac <= wdata[AS0_SHUTDOWN_STATE_AC+1:AS0_SHUTDOWN_STATE_AC];
      end
      if (wr_as1) shutdown_source_enable_bit <= wdata;
      if (wr_str) begin
        override_level <= wdata[STR_OVR+3:STR_OVR];
        steering_enable <= wdata[3:0];
      end
    end
  end

  // (RQ19) dead-band counts survive reset
  always_ff @(posedge clk) begin
    if (ce) begin
      if (wr_dbr) rising_deadband_value <= wdata[DB_W-1:0];
      if (wr_dbf) falling_deadband_value <= wdata[DB_W-1:0];
    end
  end

  // Dead-band buffers, loaded by the load sequence; they track freely while disabled
  logic [DB_W-1:0] rdb_buf, fdb_buf;
  ld_state_e ld_state;
  logic ld_fire;
  assign ld_fire = (ld_state == LD_WAIT_RISE) & data_rise;

  // (RQ21) load sequence
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ld_state <= LD_IDLE;
      load_deadband_buffers <= 1'b0;
    end else if (ce) begin
      case (ld_state)
        LD_IDLE: begin
          // Load can only be set once the module is already enabled
          if (wr_con0 & wdata[CON0_LD] & en_reg) begin
            load_deadband_buffers <= 1'b1;
            ld_state <= LD_WAIT_FALL;
          end
        end
        LD_WAIT_FALL: begin
          if (data_fall) ld_state <= LD_WAIT_RISE;
        end
        LD_WAIT_RISE: begin
          if (data_rise) begin
            load_deadband_buffers <= 1'b0;
            ld_state <= LD_IDLE;
          end
        end
        default: ld_state <= LD_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (ce && (!en_reg || ld_fire)) begin
      rdb_buf <= rising_deadband_value;
      fdb_buf <= falling_deadband_value;
    end
  end

  // Dead-band delay chains: channel 0 delays rises, channel 1 delays falls
  logic [1:0] chan_in, chan_out;
  logic [DB_W-1:0] db_val [2], db_cnt [2];
  assign chan_in = {~data_in, data_in};
  assign db_val[0] = rdb_buf;
  assign db_val[1] = fdb_buf;

  generate
    for (genvar c = 0; c < 2; c++) begin : g_db
      // (RQ16) (RQ17) (RQ18) edge delay counter
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          chan_out[c] <= 1'b0;
          db_cnt[c] <= '0;
        end else if (ce) begin
          if (!chan_in[c]) begin
            chan_out[c] <= 1'b0;
            db_cnt[c] <= db_val[c];
          end else if (db_cnt[c] == '0) begin
            chan_out[c] <= 1'b1;
          end else if (db_tick) begin
            db_cnt[c] <= db_cnt[c] - 1'b1;
          end
        end
      end
    end
  endgenerate

  // Auto-shutdown
  logic src_any, sd_event, hold_reg, shut_active, shut_q_reg, inact_ready;
  logic [DB_W-1:0] inact_cnt;
  // (RQ15) per-source enables, reserved bit ignored
  assign src_any = |(shutdown_src & shutdown_source_enable_bit[NUM_SRC-1:0]);
  assign sd_event = en_reg & src_any;
  assign shut_active = shutdown_reg | hold_reg;
  // Never ready in the first shutdown cycle, when the wait count is only being loaded
  assign inact_ready = shut_q_reg & (inact_cnt == '0);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shutdown_reg <= 1'b0;
    // (RQ22) source sets shutdown
    end else if (ce) begin
      if (sd_event) begin
        // A hardware event beats a software clear in the same cycle
        shutdown_reg <= 1'b1;
      // (RQ11) software write, also while disabled
      end else if (wr_as0) begin
        shutdown_reg <= wdata[AS0_SHUT];
      // (RQ9) auto-restart clear
      end else if (ren_reg & ~src_any) begin
        shutdown_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hold_reg <= 1'b0;
      shut_q_reg <= 1'b0;
      inact_cnt <= '0;
      data_q_reg <= 1'b0;
    end else if (ce) begin
      data_q_reg <= data_in;
      shut_q_reg <= shut_active;
      // (RQ10) hold until data rises
      if (shutdown_reg) begin
        hold_reg <= 1'b1;
      end else if (data_rise) begin
        hold_reg <= 1'b0;
      end
      // (RQ14) dead-band wait before inactive level
      if (shut_active & ~shut_q_reg) begin
        inact_cnt <= fdb_buf;
      end else if ((inact_cnt != '0) && db_tick) begin
        inact_cnt <= inact_cnt - 1'b1;
      end
    end
  end

  // Steering enables, double-buffered in synchronous mode
  logic [NUM_OUT-1:0] str_eff;
  logic steer_mode;
  // (RQ6) steering modes are 00x
  assign steer_mode = (mode_reg[2:1] == 2'h0);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      str_eff <= 4'h0;
    // (RQ7) double buffer in synchronous mode
    end else if (ce && ((mode_reg != MODE_SYNC_STEER) || data_rise)) begin
      str_eff <= steering_enable;
    end
  end

  // Output stage
  generate
    for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
      logic norm_lvl;
      logic run_lvl;
      logic [1:0] sd_code;
      // A and C take the rise-delayed chain, B and D the fall-delayed one
      assign sd_code = (i % 2 == 0) ? shutdown_state_ac : shutdown_state_bd;
      always_comb begin
        run_lvl = (i % 2 == 0) ? chan_out[0] : chan_out[1];
        if (steer_mode) begin
          // (RQ4) (RQ5) steering or override
          norm_lvl = str_eff[i] ? (data_in ^ output_invert[i]) : override_level[i];
        end else if (mode_reg <= MODE_PUSH_PULL) begin
          // (RQ1) (RQ20) polarity on bridge and push-pull modes
          norm_lvl = run_lvl ^ output_invert[i];
        end else begin
          norm_lvl = output_invert[i];
        end
      end

      always_ff @(posedge clk) begin
        if (!rst_n) begin
          drive.level[i] <= 1'b0;
          drive.oe[i] <= 1'b0;
        end else if (ce) begin
          // (RQ12) (RQ13) shutdown states
          if (shut_active) begin
            case (sd_code)
              SD_HIGH: begin
                drive.level[i] <= 1'b1;
                drive.oe[i] <= 1'b1;
              end
              SD_LOW: begin
                drive.level[i] <= 1'b0;
                drive.oe[i] <= 1'b1;
              end
              SD_TRI: begin
                drive.level[i] <= 1'b0;
                drive.oe[i] <= 1'b0;
              end
              default: begin
                drive.level[i] <= inact_ready ? output_invert[i] : drive.level[i];
                drive.oe[i] <= 1'b1;
              end
            endcase
          end else if (!en_reg) begin
            // Disabled: pins released, level parked at the inactive state
            drive.level[i] <= output_invert[i];
            drive.oe[i] <= 1'b0;
          end else begin
            drive.level[i] <= norm_lvl;
            drive.oe[i] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // Checks
  AST_STEER_POL: assert property (@(posedge clk) disable iff (!rst_n) // RQ4
    ce && en_reg && steer_mode && !shut_active && str_eff[0]
      |=> drive.level[0] == ($past(data_in) ^ $past(output_invert[0])))
    else $error("steered output A does not follow data with polarity");
  AST_OVERRIDE: assert property (@(posedge clk) disable iff (!rst_n) // RQ5
    ce && en_reg && steer_mode && !shut_active && !str_eff[1]
      |=> drive.level[1] == $past(override_level[1]) && drive.oe[1])
    else $error("override level not driven on output B");
  AST_SYNC_BUF: assert property (@(posedge clk) disable iff (!rst_n) // RQ7
    mode_reg == MODE_SYNC_STEER && !data_rise |=> $stable(str_eff))
    else $error("steering enable changed without a data rising edge");
  AST_SD_SET: assert property (@(posedge clk) disable iff (!rst_n) // RQ22
    ce && sd_event |=> shutdown_reg ##1 (hold_reg || !$past(ce)))
    else $error("enabled shutdown source did not set shutdown");
  AST_AUTORESTART: assert property (@(posedge clk) disable iff (!rst_n) // RQ9
    ce && shutdown_reg && ren_reg && !src_any && !wr_as0 |=> !shutdown_reg)
    else $error("auto-restart did not clear shutdown");
  AST_HOLD: assert property (@(posedge clk) disable iff (!rst_n) // RQ10
    hold_reg && !shutdown_reg && !(ce && data_rise) |=> hold_reg)
    else $error("shutdown hold released without data rising edge");
  AST_SD_HIGH: assert property (@(posedge clk) disable iff (!rst_n) // RQ13
    ce && shut_active && shutdown_state_ac == SD_HIGH |=> drive.level[0] && drive.oe[0])
    else $error("output A not driven high in shutdown");
  AST_SD_TRI: assert property (@(posedge clk) disable iff (!rst_n) // RQ12
    ce && shut_active && shutdown_state_bd == SD_TRI |=> !drive.oe[1] && !drive.oe[3])
    else $error("outputs B and D not released in shutdown");
  AST_DB_BYPASS: assert property (@(posedge clk) disable iff (!rst_n) // RQ18
    ce && chan_in[0] && db_cnt[0] == '0 |=> chan_out[0])
    else $error("zero rising dead band did not pass the edge");
  AST_SD_INACT_WAIT: assert property (@(posedge clk) disable iff (!rst_n) // RQ14
    ce && shut_active && !shut_q_reg && shutdown_state_ac == SD_INACTIVE
      |=> $stable(drive.level[0]))
    else $error("inactive shutdown level applied before the dead band");

endmodule : complementary_waveform_control

/* File: logic/waveform_ctrl_pkg.sv */
// Constants, register map and carrier types for the complementary waveform controller
package waveform_ctrl_pkg;

  localparam int ADDR_W = 12;
  localparam int NUM_OUT = 4;
  localparam int NUM_SRC = 7;
  localparam int DB_W = 6;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_CLK = 10'h3BC;
  localparam logic [9:0] IDX_ISM = 10'h3BD;
  localparam logic [9:0] IDX_DBR = 10'h3BE;
  localparam logic [9:0] IDX_DBF = 10'h3BF;
  localparam logic [9:0] IDX_CON0 = 10'h3C0;
  localparam logic [9:0] IDX_CON1 = 10'h3C1;
  localparam logic [9:0] IDX_AS0 = 10'h3C2;
  localparam logic [9:0] IDX_AS1 = 10'h3C3;
  localparam logic [9:0] IDX_STR = 10'h3C4;

  // Field positions
  localparam int CON0_EN = 7;
  localparam int CON0_LD = 6;
  localparam int AS0_SHUT = 7;
  localparam int AS0_REN = 6;
  localparam int AS0_SHUTDOWN_STATE_BD = 4;
  localparam int AS0_SHUTDOWN_STATE_AC = 2;
  localparam int STR_OVR = 4;

  // Reset values
  localparam logic [1:0] SHUTDOWN_STATE_BD_RST = 2'h1;
  localparam logic [1:0] SHUTDOWN_STATE_AC_RST = 2'h1;
  localparam logic [2:0] MODE_RST = 3'h0;

  // Mode codes
  localparam logic [2:0] MODE_ASYNC_STEER = 3'h0;
  localparam logic [2:0] MODE_SYNC_STEER = 3'h1;
  localparam logic [2:0] MODE_FWD_FULL = 3'h2;
  localparam logic [2:0] MODE_REV_FULL = 3'h3;
  localparam logic [2:0] MODE_HALF = 3'h4;
  localparam logic [2:0] MODE_PUSH_PULL = 3'h5;

  // Shutdown state codes
  localparam logic [1:0] SD_HIGH = 2'h3;
  localparam logic [1:0] SD_LOW = 2'h2;
  localparam logic [1:0] SD_TRI = 2'h1;
  localparam logic [1:0] SD_INACTIVE = 2'h0;

  typedef enum logic [1:0] {LD_IDLE, LD_WAIT_FALL, LD_WAIT_RISE} ld_state_e;

  typedef struct packed {
    logic hsel;
    logic [ADDR_W-1:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } ahb_req_s;

  typedef struct packed {
    logic [NUM_OUT-1:0] level;
    logic [NUM_OUT-1:0] oe;
  } pin_drive_s;

endpackage : waveform_ctrl_pkg

/* File: testbench/complementary_waveform_control_bench.sv */
// Self-checking bench for the complementary waveform controller
module complementary_waveform_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import waveform_ctrl_pkg::*;
  logic clk, rst_n, ce, hsel, hwrite, hreadyout, hresp, din, tick;
  logic [ADDR_W-1:0] haddr;
  logic [1:0] htrans;
  logic [31:0] hwdata, hrdata, rd;
  logic [14:0] internal_src;
  logic [NUM_SRC-1:0] shutdown_src;
  ahb_req_s ahb_req;
  pin_drive_s drive;
  logic [NUM_OUT-1:0] pin;
  logic [7:0] shc [4] = '{8'h38, 8'h3C, 8'h14, 8'h00};
  logic [3:0] shp [4] = '{4'hA, 4'hF, 4'h0, 4'hA};
  logic [3:0] sho [4] = '{4'hF, 4'hF, 4'h0, 4'hF};
  int fails, num_checks, tkc, d;

  assign ahb_req = '{hsel, haddr, htrans, hwrite, 3'h2, hwdata, hreadyout};

  complementary_waveform_control DUT (
    .clk(clk), .rst_n(rst_n), .ce(ce), .ahb_req(ahb_req), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .pin_mapped_input(din), .internal_src(internal_src),
    .shutdown_src(shutdown_src), .fast_osc_tick(tick), .drive(drive)
  );

  gate_driver_model drivers (.drive(drive), .pin(pin));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Fast oscillator stand-in: one tick every fourth clock
  always @(posedge clk) begin
    tkc <= tkc + 1;
    tick <= (tkc % 4 == 3);
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    if (fails == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  // One single transfer; the master never assumes the wait length
  task automatic bus(input logic [9:0] idx, input logic wr_en, input logic [7:0] wd);
    hsel <= 1'b1;
    haddr <= {idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr_en;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [9:0] idx, input logic [7:0] v);
    bus(idx, 1'b1, v);
  endtask : wr

  task automatic rdck(input logic [9:0] idx, input logic [7:0] exp);
    bus(idx, 1'b0, 8'h00);
    check(rd, {24'h0, exp});
  endtask : rdck

  task automatic tk(input int n);
    repeat (n) @(posedge clk);
  endtask : tk

  // Counts cycles from a data edge until output b reaches its new level
  task automatic dly(input int b, input logic v, output int n);
    din <= v;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (pin[b] !== (b[0] ? ~v : v) && n < 400);
    @(posedge clk);
  endtask : dly

  initial begin
    fails = 0;
    num_checks = 0;
    rst_n = 1'b0;
    ce = 1'b1;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = '0;
    din = 1'b0;
    internal_src = '0;
    shutdown_src = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdck(IDX_AS0, 8'h14);
    rdck(IDX_STR, 8'h00);
    rdck(IDX_ISM, 8'h00);
    rdck(IDX_CLK, 8'h00);
    rdck(10'h3FF, 8'h00);
    wr(IDX_DBR, 8'hFF);
    rdck(IDX_DBR, 8'h3F);
    wr(IDX_DBF, 8'h2A);
    rst_n <= 1'b0;
    tk(2);
    rst_n <= 1'b1;
    tk(1);
    rdck(IDX_DBR, 8'h3F);
    rdck(IDX_DBF, 8'h2A);
    wr(IDX_DBR, 8'h00);
    wr(IDX_DBF, 8'h00);
    wr(IDX_CON0, 8'h80);
    wr(IDX_STR, 8'h0F);
    for (int p = 0; p < 16; p += 5) begin
      for (int v = 0; v < 2; v++) begin
        wr(IDX_CON1, p[7:0]);
        din <= v[0];
        tk(4);
        check(pin, {4{v[0]}} ^ p[3:0]);
      end
    end
    check(drive.oe, 4'hF);
    // Clock enable low freezes the outputs, high lets the data through again
    ce <= 1'b0;
    din <= 1'b0;
    tk(4);
    check(pin, 4'h0);
    ce <= 1'b1;
    tk(4);
    check(pin, 4'hF);
    din <= 1'b1;
    wr(IDX_STR, 8'h63);
    tk(4);
    check(pin, 4'h4);
    wr(IDX_CON1, 8'h00);
    wr(IDX_STR, 8'h0F);
    din <= 1'b0;
    for (int k = 1; k < 16; k++) begin
      wr(IDX_ISM, k[7:0]);
      internal_src <= 15'h1 << (k - 1);
      tk(4);
      check(pin, 4'hF);
      internal_src <= ~(15'h1 << (k - 1));
      tk(4);
      check(pin, 4'h0);
    end
    wr(IDX_ISM, 8'h00);
    internal_src <= '0;
    wr(IDX_STR, 8'h00);
    din <= 1'b1;
    for (int m = 2; m < 8; m++) begin
      wr(IDX_CON0, 8'h80 | m[7:0]);
      tk(6);
      check(pin, (m < 6) ? 4'h5 : 4'h0);
    end
    wr(IDX_CON0, 8'h81);
    din <= 1'b0;
    tk(3);
    din <= 1'b1;
    tk(3);
    wr(IDX_STR, 8'h01);
    tk(4);
    check(pin, 4'h0);
    din <= 1'b0;
    tk(3);
    din <= 1'b1;
    tk(4);
    check(pin, 4'h1);
    wr(IDX_CON0, 8'h00);
    wr(IDX_CON0, 8'h40);
    rdck(IDX_CON0, 8'h00);
    wr(IDX_DBR, 8'h05);
    wr(IDX_DBF, 8'h00);
    wr(IDX_CON0, 8'h84);
    din <= 1'b0;
    tk(10);
    dly(0, 1'b1, d);
    check(d >= 5 && d <= 9, 1'b1);
    dly(1, 1'b0, d);
    check(d <= 4, 1'b1);
    // Load armed: first fall keeps the old count, the rise after it loads
    wr(IDX_DBF, 8'h07);
    wr(IDX_CON0, 8'hC4);
    dly(0, 1'b1, d);
    dly(1, 1'b0, d);
    check(d <= 4, 1'b1);
    dly(0, 1'b1, d);
    dly(1, 1'b0, d);
    check(d >= 7 && d <= 11, 1'b1);
    rdck(IDX_CON0, 8'h84);
    wr(IDX_CLK, 8'h01);
    tk(4);
    dly(0, 1'b1, d);
    check(d >= 17 && d <= 30, 1'b1);
    wr(IDX_CLK, 8'h00);
    wr(IDX_CON0, 8'h80);
    wr(IDX_CON1, 8'h0A);
    rdck(IDX_CON1, 8'h2A);
    wr(IDX_STR, 8'h0F);
    for (int s = 0; s < 7; s++) begin
      wr(IDX_AS0, shc[s % 4]);
      wr(IDX_AS1, 8'h01 << s);
      din <= 1'b1;
      shutdown_src <= 7'h1 << ((s + 1) % 7);
      tk(4);
      rdck(IDX_AS0, shc[s % 4]);
      check(pin, 4'h5);
      shutdown_src <= 7'h1 << s;
      tk(14);
      rdck(IDX_AS0, 8'h80 | shc[s % 4]);
      check(pin, shp[s % 4]);
      check(drive.oe, sho[s % 4]);
      shutdown_src <= '0;
      din <= 1'b0;
      tk(4);
      rdck(IDX_AS0, 8'h80 | shc[s % 4]);
      wr(IDX_AS0, shc[s % 4]);
      tk(4);
      check(pin, shp[s % 4]);
      din <= 1'b1;
      tk(4);
      check(pin, 4'h5);
    end
    wr(IDX_AS0, 8'h7C);
    wr(IDX_AS1, 8'h7F);
    shutdown_src <= 7'h10;
    tk(4);
    rdck(IDX_AS0, 8'hFC);
    shutdown_src <= '0;
    tk(4);
    rdck(IDX_AS0, 8'h7C);
    wr(IDX_CON0, 8'h00);
    wr(IDX_AS0, 8'h14);
    shutdown_src <= 7'h01;
    tk(4);
    rdck(IDX_AS0, 8'h14);
    shutdown_src <= '0;
    wr(IDX_AS0, 8'hBC);
    tk(2);
    rdck(IDX_AS0, 8'hBC);
    check(pin, 4'hF);
    give_verdict();
  end

  // Watchdog well beyond the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    give_verdict();
  end
endmodule : complementary_waveform_control_bench

/* File: testbench/gate_driver_model.sv */
// Gate driver model: resolves the four controller outputs into driver input levels
module gate_driver_model (
  input wire waveform_ctrl_pkg::pin_drive_s drive, // Controller output group
  output logic [waveform_ctrl_pkg::NUM_OUT-1:0] pin // Levels seen by the drivers
);
  timeunit 1ns;
  timeprecision 1ps;
  import waveform_ctrl_pkg::*;
  // released pins
  // A released pin falls to the driver input pull-down, never holds the old level
  always_comb begin
    for (int i = 0; i < NUM_OUT; i++) begin
      pin[i] = drive.oe[i] ? drive.level[i] : 1'b0;
    end
  end
endmodule : gate_driver_model
